// [include/mgmt_params.svh]
// Purpose: constants for the module management and control block
// Assumes: core clock of 200 MHz
// Notes: offsets below 8'h80 are lower-page byte addresses, those from 8'h80 up are upper
`ifndef MGMT_PARAMS_SVH
`define MGMT_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ 200000
`define CLK_PER_US 200
`define T_INIT_MS 2000
`define INIT_CYCLES_DEF (`T_INIT_MS * `CLK_KHZ)
`define T_RST_MIN_US 2
`define RST_MIN_CYCLES (`T_RST_MIN_US * `CLK_PER_US)
`define INIT_CNT_W 29
`define RST_CNT_W 9

// ----------------------------------------------------------------
// serial address and register offsets
// ----------------------------------------------------------------
`define DEV_ADDR 7'h50
`define OFS_STATUS 8'h02
`define OFS_LOS 8'h03
`define OFS_FAULT 8'h04
`define OFS_TXDIS 8'h56
`define OFS_PWR 8'h5D
`define OFS_MASK_LOS 8'h64
`define OFS_MASK_FLT 8'h65
`define OFS_PAGE 8'h7F
`define OFS_SQDIS 8'hF0
`define OFS_RXDIS 8'hF1
`define PAGE_CTRL 2'h3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BIT_NOT_READY 0
`define BIT_INT_STAT 1
`define BIT_PDOWN 1
`define RST_CTRL 8'h00
`define RST_PAGE 2'h0

`endif

// [include/mgmt_pkg.sv]
// Purpose: shared types of the management block
// Assumes: nothing
// Notes: state codes are Gray along the write path
package mgmt_pkg;

    typedef enum logic [3:0] {
        TW_IDLE = 4'h0,
        TW_ADDR = 4'h1,
        TW_ACK_A = 4'h3,
        TW_OFS = 4'h2,
        TW_ACK_O = 4'h6,
        TW_WDAT = 4'h7,
        TW_ACK_W = 4'h5,
        TW_RDAT = 4'h4,
        TW_RACK = 4'hC
    } tw_state_t;

    typedef logic [3:0] lane_vec_t;

endpackage : mgmt_pkg

// [logic/bit_sync.sv]
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are slow against clk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r <= INIT;
            dout <= INIT;
        end
        else if (ce)
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : bit_sync

`default_nettype wire

// [logic/page_mem.sv]
// Purpose: byte memory behind lower and upper pages
// Assumes: one write or read per cycle
// Notes: read data come out of a register
`timescale 1ns/1ps
`default_nettype none

module page_mem (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:1023];

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end

endmodule : page_mem

`default_nettype wire

// [logic/module_mgmt_control_timing.sv]
// Purpose: management slave, flags, interrupt and lane controls
// Assumes: scl, sda and control pins are asynchronous to clk
// Notes: actions land a few cycles after their cause, except soft reset (400 low cycles) and ready (INIT_CYCLES)
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_params.svh"

module module_mgmt_control_timing
    import mgmt_pkg::*;
#(
    parameter int INIT_CYCLES = `INIT_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    output logic attention_out_n_o,
    output logic attention_out_n_oe,
    input wire logic [3:0] rx_los_in,
    input wire logic [3:0] tx_los_in,
    input wire logic [3:0] tx_fault_in,
    output logic power_level1,
    output logic [3:0] rx_out_en,
    output logic [3:0] tx_out_en,
    output logic module_ready
);

    localparam int RST_MIN = `RST_MIN_CYCLES;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s, sda_s, sel_n_s, rst_n_s, lp_s;
    lane_vec_t rx_los_s, tx_los_s, tx_flt_s;

    bit_sync #(.WIDTH(5), .INIT(5'h1E)) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .din({scl_i, sda_i, module_select_n, module_reset_n,
              low_power_request}),
        .dout({scl_s, sda_s, sel_n_s, rst_n_s, lp_s})
    );

    bit_sync #(.WIDTH(12), .INIT(12'h000)) u_stat_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .din({rx_los_in, tx_los_in, tx_fault_in}),
        .dout({rx_los_s, tx_los_s, tx_flt_s})
    );

    // ----------------------------------------------------------------
    // reset pulse qualification and init counter
    // ----------------------------------------------------------------
    logic [`RST_CNT_W-1:0] rst_low_cnt_r;
    logic soft_rst_r;
    logic [`INIT_CNT_W-1:0] init_cnt_r;
    logic not_ready_r;
    logic init_done;
    logic core_rst;

    assign core_rst = sys_rst | soft_rst_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rst_low_cnt_r <= '0;
            soft_rst_r <= 1'b0;
        end
        else if (ce)
        begin
            if (rst_n_s)
            begin
                rst_low_cnt_r <= '0;
                soft_rst_r <= 1'b0;
            end
            else if (rst_low_cnt_r == `RST_CNT_W'(RST_MIN - 1))
            begin
                soft_rst_r <= 1'b1;
            end
            else
            begin
                rst_low_cnt_r <= rst_low_cnt_r + 1'b1;
            end
        end
    end

    assign init_done = not_ready_r &&
        (init_cnt_r == `INIT_CNT_W'(INIT_CYCLES - 1));

    always_ff @(posedge clk)
    begin
        if (core_rst)
        begin
            init_cnt_r <= '0;
            not_ready_r <= 1'b1;
        end
        else if (ce && not_ready_r)
        begin
            init_cnt_r <= init_cnt_r + 1'b1;
            if (init_done)
            begin
                not_ready_r <= 1'b0;
            end
        end
    end

    assign module_ready = ~not_ready_r;

    // ----------------------------------------------------------------
    // two-wire serial slave
    // ----------------------------------------------------------------
    tw_state_t st_r;
    logic scl_d_r, sda_d_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r, tx_sh_r, ptr_r;
    logic rw_r, wr_pulse, rd_load;
    logic [1:0] page_r;
    logic [7:0] rd_byte, mem_rdata;
    logic [9:0] mem_addr;
    logic scl_rise, scl_fall, start_c, stop_c, active;

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign active = ~sel_n_s & ~not_ready_r;
    assign wr_pulse = ce && st_r == TW_WDAT && scl_fall &&
        bit_cnt_r == 4'h8 && active && !start_c && !stop_c;
    assign rd_load = ce && active && !start_c && !stop_c && scl_fall &&
        ((st_r == TW_ACK_A && rw_r) || (st_r == TW_RACK && !sda_d_r));
    assign sda_o = 1'b0;

    always_ff @(posedge clk)
    begin
        if (core_rst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (ce)
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    always_ff @(posedge clk)
    begin
        if (core_rst)
        begin
            st_r <= TW_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (ce)
        begin
            if (!active || stop_c)
            begin
                st_r <= TW_IDLE;
                sda_oe <= 1'b0;
            end
            else if (start_c)
            begin
                st_r <= TW_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                shift_r <= {shift_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 1'b1;
                if (st_r == TW_RACK && sda_s)
                begin
                    st_r <= TW_IDLE;
                end
            end
            else if (scl_fall)
            begin
                case (st_r)
                    TW_ADDR:
                    begin
                        if (bit_cnt_r == 4'h8)
                        begin
                            if (shift_r[7:1] == `DEV_ADDR)
                            begin
                                st_r <= TW_ACK_A;
                                rw_r <= shift_r[0];
                                sda_oe <= 1'b1;
                            end
                            else
                            begin
                                st_r <= TW_IDLE;
                            end
                        end
                    end
                    TW_ACK_A, TW_RACK:
                    begin
                        bit_cnt_r <= 4'h0;
                        if (rd_load)
                        begin
                            st_r <= TW_RDAT;
                            sda_oe <= ~rd_byte[7];
                            tx_sh_r <= {rd_byte[6:0], 1'b0};
                        end
                        else
                        begin
                            st_r <= TW_OFS;
                            sda_oe <= 1'b0;
                        end
                    end
                    TW_OFS, TW_WDAT:
                    begin
                        if (bit_cnt_r == 4'h8)
                        begin
                            st_r <= (st_r == TW_OFS) ? TW_ACK_O : TW_ACK_W;
                            ptr_r <= (st_r == TW_OFS) ? shift_r :
                                ptr_r + 1'b1;
                            sda_oe <= 1'b1;
                        end
                    end
                    TW_ACK_O, TW_ACK_W:
                    begin
                        st_r <= TW_WDAT;
                        bit_cnt_r <= 4'h0;
                        sda_oe <= 1'b0;
                    end
                    TW_RDAT:
                    begin
                        if (bit_cnt_r == 4'h8)
                        begin
                            st_r <= TW_RACK;
                            ptr_r <= ptr_r + 1'b1;
                            sda_oe <= 1'b0;
                        end
                        else
                        begin
                            sda_oe <= ~tx_sh_r[7];
                            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        end
                    end
                    default:
                    begin
                        st_r <= TW_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // paged memory and control registers
    // ----------------------------------------------------------------
    logic [7:0] tx_dis_r, pwr_r, mask_los_r, mask_flt_r, sqdis_r, rxdis_r;
    logic upper_ctrl;

    assign upper_ctrl = ptr_r[7] && page_r == `PAGE_CTRL;
    assign mem_addr = ptr_r[7] ? {1'b1, page_r, ptr_r[6:0]} :
        {3'b000, ptr_r[6:0]};

    page_mem u_mem (
        .clk(clk),
        .ce(ce),
        .we(wr_pulse),
        .addr(mem_addr),
        .wdata(shift_r),
        .rdata(mem_rdata)
    );

    always_ff @(posedge clk)
    begin
        if (core_rst)
        begin
            tx_dis_r <= `RST_CTRL;
            pwr_r <= `RST_CTRL;
            mask_los_r <= `RST_CTRL;
            mask_flt_r <= `RST_CTRL;
            sqdis_r <= `RST_CTRL;
            rxdis_r <= `RST_CTRL;
            page_r <= `RST_PAGE;
        end
        else if (wr_pulse)
        begin
            if (ptr_r == `OFS_TXDIS)
                tx_dis_r <= shift_r;
            if (ptr_r == `OFS_PWR)
                pwr_r <= shift_r;
            if (ptr_r == `OFS_MASK_LOS)
                mask_los_r <= shift_r;
            if (ptr_r == `OFS_MASK_FLT)
                mask_flt_r <= shift_r;
            if (ptr_r == `OFS_PAGE)
                page_r <= shift_r[1:0];
            if (upper_ctrl && ptr_r == `OFS_SQDIS)
                sqdis_r <= shift_r;
            if (upper_ctrl && ptr_r == `OFS_RXDIS)
                rxdis_r <= shift_r;
        end
    end

    // ----------------------------------------------------------------
    // latched flags and attention output
    // ----------------------------------------------------------------
    lane_vec_t rx_los_f_r, tx_los_f_r, tx_flt_f_r, tx_flt_hold_r;
    logic init_flag_r, int_src, clr_los, clr_flt, clr_stat;

    assign clr_los = rd_load && ptr_r == `OFS_LOS;
    assign clr_flt = rd_load && ptr_r == `OFS_FAULT;
    assign clr_stat = rd_load && ptr_r == `OFS_STATUS;

    always_comb
    begin
        rd_byte = mem_rdata;
        case (ptr_r)
            `OFS_STATUS:
            begin
                rd_byte = 8'h00;
                rd_byte[`BIT_NOT_READY] = not_ready_r;
                rd_byte[`BIT_INT_STAT] = ~attention_out_n_oe;
            end
            `OFS_LOS: rd_byte = {tx_los_f_r, rx_los_f_r};
            `OFS_FAULT: rd_byte = {4'h0, tx_flt_f_r};
            `OFS_TXDIS: rd_byte = tx_dis_r;
            `OFS_PWR: rd_byte = pwr_r;
            `OFS_MASK_LOS: rd_byte = mask_los_r;
            `OFS_MASK_FLT: rd_byte = mask_flt_r;
            `OFS_PAGE: rd_byte = {6'h00, page_r};
            `OFS_SQDIS: rd_byte = upper_ctrl ? sqdis_r : mem_rdata;
            `OFS_RXDIS: rd_byte = upper_ctrl ? rxdis_r : mem_rdata;
            default: rd_byte = mem_rdata;
        endcase
    end

    // a set in the cycle of a clear-on-read wins over the clear
    always_ff @(posedge clk)
    begin
        if (core_rst)
        begin
            rx_los_f_r <= 4'h0;
            tx_los_f_r <= 4'h0;
            tx_flt_f_r <= 4'h0;
            init_flag_r <= 1'b0;
        end
        else if (ce)
        begin
            rx_los_f_r <= (rx_los_f_r & ~{4{clr_los}}) |
                rx_los_s;
            tx_los_f_r <= (tx_los_f_r & ~{4{clr_los}}) |
                tx_los_s;
            tx_flt_f_r <= (tx_flt_f_r & ~{4{clr_flt}}) |
                tx_flt_s;
            init_flag_r <= (init_flag_r & ~clr_stat) | init_done;
        end
    end

    assign int_src = |(rx_los_f_r & ~mask_los_r[3:0]) |
        |(tx_los_f_r & ~mask_los_r[7:4]) |
        |(tx_flt_f_r & ~mask_flt_r[3:0]) | init_flag_r;

    always_ff @(posedge clk)
    begin
        if (core_rst)
            attention_out_n_oe <= 1'b0;
        else if (ce)
            attention_out_n_oe <= int_src;
    end

    assign attention_out_n_o = 1'b0;

    // ----------------------------------------------------------------
    // power and lane output control
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (core_rst)
            tx_flt_hold_r <= 4'h0;
        else if (ce)
            tx_flt_hold_r <= (tx_flt_hold_r & ~tx_dis_r[3:0]) | tx_flt_s;
    end

    always_ff @(posedge clk)
    begin
        if (core_rst)
        begin
            power_level1 <= 1'b1;
            rx_out_en <= 4'h0;
            tx_out_en <= 4'h0;
        end
        else if (ce)
        begin
            power_level1 <= lp_s |
                pwr_r[`BIT_PDOWN] | not_ready_r;
            rx_out_en <= ~rxdis_r[7:4] & ~(rx_los_s & ~sqdis_r[7:4]) &
                {4{~not_ready_r}};
            tx_out_en <= ~tx_dis_r[3:0] & ~tx_flt_hold_r &
                ~(tx_los_s & ~sqdis_r[3:0]) &
                {4{~(lp_s | pwr_r[`BIT_PDOWN] | not_ready_r)}};
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_init_end;
        $fell(not_ready_r) ##0 init_flag_r;
    endsequence

    a_init_attention: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        s_init_end |-> ##1 attention_out_n_oe)
        else $error("attention not raised after init");
    a_reset_qualify: assert property (@(posedge clk)
        disable iff (sys_rst || !ce)
        (!rst_n_s && rst_low_cnt_r == `RST_CNT_W'(RST_MIN - 1))
        |=> soft_rst_r)
        else $error("long reset pulse not taken");
    a_lowpower_entry: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        $rose(lp_s) |=> power_level1 && tx_out_en == 4'h0)
        else $error("low power not entered");
    a_rxlos_attention: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        (rx_los_s[0] && !mask_los_r[0]) |-> ##2 attention_out_n_oe)
        else $error("receive loss did not raise attention");
    a_flag_release: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        $fell(int_src) |=> !attention_out_n_oe)
        else $error("attention not released");
    a_flag_latch: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        (tx_flt_s[0] ##1 !clr_flt) |=> tx_flt_f_r[0])
        else $error("fault flag lost");
    a_select_gate: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        sel_n_s |=> !sda_oe && st_r == TW_IDLE)
        else $error("slave active while deselected");
    a_rx_squelch: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        (rx_los_s[0] && !sqdis_r[4]) |=> !rx_out_en[0])
        else $error("receive squelch missing");
    a_tx_disable: assert property (@(posedge clk)
        disable iff (core_rst || !ce)
        tx_dis_r[0] |=> !tx_out_en[0])
        else $error("transmit disable ignored");

endmodule : module_mgmt_control_timing

`default_nettype wire

// [dv/host_mgmt_master.sv]
// Purpose: host management master on the two-wire bus
// Assumes: 80 ns bus clock, data line pulled up
// Notes: bus clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_params.svh"

module host_mgmt_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    logic ack;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (4) @(negedge clk);
    endtask : q
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        q();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask : stop
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : tx
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        start();
        tx({`DEV_ADDR, 1'b0});
        tx(ofs);
        tx(d);
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        logic r;
        start();
        tx({`DEV_ADDR, 1'b0});
        tx(ofs);
        start();
        tx({`DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop();
    endtask : rd
endmodule : host_mgmt_master
`default_nettype wire

// [dv/tb_module_mgmt_control_timing.sv]
// Purpose: self-checking bench of the management block
// Assumes: init count shortened to 200 cycles
// Notes: pins change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_params.svh"
`define CHK(a, e) \
    begin \
        check_count++; \
        if ((a) !== (e)) \
        begin \
            fails++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, a, e); \
        end \
    end

module tb_module_mgmt_control_timing;
    logic clk, sys_rst, module_select_n, module_reset_n, low_power_request;
    logic [3:0] rx_los_in, tx_los_in, tx_fault_in;
    logic [7:0] d;
    wire logic scl, sda_low, sda_oe, att_oe, power_level1, module_ready;
    wire logic sda_out, att_o;
    wire logic [3:0] rx_out_en, tx_out_en;
    wire logic sda = !(sda_low || sda_oe);
    int fails = 0;
    int check_count = 0;
    host_mgmt_master host (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    module_mgmt_control_timing #(.INIT_CYCLES(200)) uut (.clk(clk),
        .sys_rst(sys_rst), .ce(1'b1), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_out),
        .sda_oe(sda_oe), .module_select_n(module_select_n),
        .module_reset_n(module_reset_n),
        .low_power_request(low_power_request), .attention_out_n_o(att_o),
        .attention_out_n_oe(att_oe), .rx_los_in(rx_los_in),
        .tx_los_in(tx_los_in), .tx_fault_in(tx_fault_in),
        .power_level1(power_level1), .rx_out_en(rx_out_en),
        .tx_out_en(tx_out_en), .module_ready(module_ready));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic w8();
        repeat (8) @(negedge clk);
    endtask : w8
    task automatic t_init();
        host.start();
        host.tx({`DEV_ADDR, 1'b0});
        `CHK(host.ack, 1'b0)
        host.stop();
        repeat (60) @(negedge clk);
        `CHK(module_ready, 1'b1)
        `CHK(att_oe, 1'b1)
        host.rd(`OFS_STATUS, d);
        `CHK(d[0], 1'b0)
        `CHK(d[1], 1'b0)
        `CHK(att_o, 1'b0)
        w8();
        `CHK(att_oe, 1'b0)
        module_select_n = 1'b1;
        host.wr(`OFS_TXDIS, 8'h0F);
        `CHK(host.ack, 1'b0)
        `CHK(tx_out_en, 4'hF)
        `CHK(sda_out, 1'b0)
        module_select_n = 1'b0;
    endtask : t_init
    task automatic t_flags();
        rx_los_in = 4'h4;
        tx_los_in = 4'h8;
        tx_fault_in = 4'h3;
        w8();
        `CHK(att_oe, 1'b1)
        `CHK(rx_out_en, 4'hB)
        `CHK(tx_out_en, 4'h4)
        rx_los_in = 4'h0;
        tx_los_in = 4'h0;
        tx_fault_in = 4'h0;
        w8();
        `CHK(tx_out_en, 4'hC)
        host.rd(`OFS_LOS, d);
        `CHK(d, 8'h84)
        host.rd(`OFS_FAULT, d);
        `CHK(d, 8'h03)
        host.rd(`OFS_LOS, d);
        `CHK(d, 8'h00)
        w8();
        `CHK(att_oe, 1'b0)
        host.wr(`OFS_MASK_LOS, 8'hFF);
        `CHK(host.ack, 1'b1)
        rx_los_in = 4'h1;
        w8();
        `CHK(att_oe, 1'b0)
        host.wr(`OFS_MASK_LOS, 8'h00);
        w8();
        `CHK(att_oe, 1'b1)
        rx_los_in = 4'h0;
        host.rd(`OFS_LOS, d);
    endtask : t_flags
    task automatic t_ctrl();
        host.wr(`OFS_TXDIS, 8'h0B);
        `CHK(tx_out_en, 4'h4)
        host.wr(`OFS_TXDIS, 8'h00);
        `CHK(tx_out_en, 4'hF)
        host.wr(`OFS_PAGE, {6'h00, `PAGE_CTRL});
        host.wr(`OFS_RXDIS, 8'h30);
        `CHK(rx_out_en, 4'hC)
        host.wr(`OFS_SQDIS, 8'h40);
        rx_los_in = 4'h4;
        w8();
        `CHK(rx_out_en, 4'hC)
        rx_los_in = 4'h0;
        low_power_request = 1'b1;
        w8();
        `CHK(power_level1, 1'b1)
        low_power_request = 1'b0;
        host.wr(`OFS_PWR, 8'h02);
        `CHK(power_level1, 1'b1)
        host.wr(`OFS_PWR, 8'h00);
        `CHK(power_level1, 1'b0)
    endtask : t_ctrl
    task automatic t_rst();
        module_reset_n = 1'b0;
        repeat (100) @(negedge clk);
        module_reset_n = 1'b1;
        w8();
        `CHK(module_ready, 1'b1)
        module_reset_n = 1'b0;
        repeat (420) @(negedge clk);
        `CHK(module_ready, 1'b0)
        module_reset_n = 1'b1;
        repeat (220) @(negedge clk);
        `CHK(module_ready, 1'b1)
    endtask : t_rst
    task automatic close_out();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial
    begin
        sys_rst = 1'b1;
        module_select_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
        rx_los_in = 4'h0;
        tx_los_in = 4'h0;
        tx_fault_in = 4'h0;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        t_init();
        t_flags();
        t_ctrl();
        t_rst();
        close_out();
    end
    initial
    begin
        #300000;
        fails++;
        close_out();
    end
endmodule : tb_module_mgmt_control_timing
`default_nettype wire
